// [rtl/triple_timer_cfg.svh]
// Constants for the three-timer module: prescaler, step timing, timer indices and reset values.
`ifndef TRIPLE_TIMER_CFG_SVH
`define TRIPLE_TIMER_CFG_SVH
`define TT_CLK_HZ 20000000
`define TT_STATE_TIME_NS 25
`define TT_MIN_STEP_STATE_TIMES 16
`define TT_MIN_STEP_CYCLES ((`TT_MIN_STEP_STATE_TIMES * `TT_STATE_TIME_NS + 49) / 50)
`define TT_PRESCALE_W 3
`define TT_DIV_W 16
`define TT_TIMER_W 16
`define TT_TIMER_RST 16'h0000
`define TT_IDX_LOW 0
`define TT_IDX_CORE 1
`define TT_IDX_HIGH 2
`endif

// [rtl/triple_timer_pkg.sv]
// Types shared by the three-timer module.
package triple_timer_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_GATED = 2'h1,
    MODE_COUNTER = 2'h3,
    MODE_INCREMENTAL = 2'h2
  } mode_t;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_t;
  typedef struct packed {
    mode_t mode;
    logic run;
    logic dir_down;
    logic ext_dir_en;
    logic gate_high;
    edge_t count_edge;
    logic [2:0] prescale;
  } timer_cfg_t;
  typedef struct packed {
    logic chain;
    logic capture;
    logic reload;
    edge_t trig_edge;
    logic reload_on_rise;
    logic reload_on_fall;
  } aux_cfg_t;
endpackage

// [rtl/triple_timer_module.sv]
// Three 16-bit up/down timers with toggle latch, chaining, capture and reload.
`include "triple_timer_cfg.svh"

// Notes on behaviour
// (RULE1) Three independent 16-bit timers: one core and two auxiliaries.
// (RULE2) Each timer picks timer, gated, counter or incremental mode.
// (RULE3) Timer mode counts on a prescaled clock divided from the system clock.
// (RULE4) Counter mode counts selected edges on the timer input pin.
// (RULE5) Gated mode counts prescaled ticks only while the gate level holds.
// (RULE6) One input pin per timer, used as gate or count input.
// (RULE7) Fastest count step is sixteen state times, eight clock cycles; only timer and gated modes keep it, pin-edge and chained steps may come closer.
// (RULE8) Direction set by software, optionally flipped by the direction pin.
// (RULE9) Incremental mode decodes quadrature A and B into count and direction.
// (RULE10) An auxiliary timer may chain to the core timer as its count source.
// (RULE11) Core toggle latch inverts on each core overflow and underflow.
// (RULE12) Toggle latch state drives the toggle output pin.
// (RULE13) Toggle latch edges may clock either auxiliary timer.
// (RULE14) An auxiliary in capture or reload duty stops counting.
// (RULE15) Capture copies the core count on the auxiliary input edge.
// (RULE16) Reload loads the core from auxiliary on pin edge or latch transition.
// (RULE17) Both auxiliaries reloading on opposite latch edges give hands-free PWM.
// (RULE18) Timers wrap at limits and flag overflow or underflow pulses.
// (RULE19) Input and direction pins pass three flip-flops before use.
module triple_timer_module (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration, index 0 low auxiliary, 1 core, 2 high auxiliary
  input triple_timer_pkg::timer_cfg_t timer_cfg [3],
  input triple_timer_pkg::aux_cfg_t aux_low_cfg,
  input triple_timer_pkg::aux_cfg_t aux_high_cfg,
  input wire logic toggle_out_en,
  // Pins
  input wire logic [2:0] timer_input_pin,
  input wire logic [2:0] direction_input_pin,
  output logic toggle_output_pin,
  // Status
  output logic [15:0] aux_timer_low,
  output logic [15:0] core_timer,
  output logic [15:0] aux_timer_high,
  output logic core_toggle_latch,
  output logic [2:0] overflow_pulse,
  output logic [2:0] underflow_pulse
);
  localparam int unsigned STEP = `TT_MIN_STEP_CYCLES;
  localparam logic [`TT_TIMER_W-1:0] TMAX = 16'hFFFF;

  triple_timer_pkg::aux_cfg_t aux_cfg [3];
  logic [2:0] in_s1_ff, in_s2_ff, in_s3_ff;
  logic [2:0] dir_s1_ff, dir_s2_ff, dir_s3_ff;
  logic [2:0] in_lvl_ff, dir_lvl_ff;
  logic [2:0] in_rise, in_fall, dir_rise, dir_fall;
  logic [`TT_DIV_W-1:0] div_ff;
  logic [2:0] base_cnt_ff;
  logic base_tick;
  logic [15:0] cnt_ff [3];
  logic [15:0] nxt_cnt [3];
  logic [2:0] step, down, ovf, unf;
  logic tl_rise, tl_fall;
  logic core_reload;
  logic [15:0] reload_val;

  assign aux_cfg[0] = aux_low_cfg;
  assign aux_cfg[1] = '0;
  assign aux_cfg[2] = aux_high_cfg;

  // Pin synchroniser; a level change counts once stages two and three agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_s1_ff <= 3'h0;
      in_s2_ff <= 3'h0;
      in_s3_ff <= 3'h0;
      dir_s1_ff <= 3'h0;
      dir_s2_ff <= 3'h0;
      dir_s3_ff <= 3'h0;
    end else if (clk_en) begin
      in_s1_ff <= timer_input_pin; // see (RULE19)
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
      dir_s1_ff <= direction_input_pin;
      dir_s2_ff <= dir_s1_ff;
      dir_s3_ff <= dir_s2_ff;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_lvl_ff <= 3'h0;
      dir_lvl_ff <= 3'h0;
    end else if (clk_en) begin
      in_lvl_ff <= (in_s2_ff & in_s3_ff) | (in_lvl_ff & (in_s2_ff | in_s3_ff));
      dir_lvl_ff <= (dir_s2_ff & dir_s3_ff) | (dir_lvl_ff & (dir_s2_ff | dir_s3_ff));
    end
  end

  assign in_rise = in_s2_ff & in_s3_ff & ~in_lvl_ff;
  assign in_fall = ~in_s2_ff & ~in_s3_ff & in_lvl_ff;
  assign dir_rise = dir_s2_ff & dir_s3_ff & ~dir_lvl_ff;
  assign dir_fall = ~dir_s2_ff & ~dir_s3_ff & dir_lvl_ff;

  // Base tick every eight cycles gives the finest step; the divider scales it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      base_cnt_ff <= (base_cnt_ff == 3'(STEP - 1)) ? 3'h0 : base_cnt_ff + 3'h1; // see (RULE7)
    end
  end
  assign base_tick = clk_en && (base_cnt_ff == 3'(STEP - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 16'h0000;
    end else if (base_tick) begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  function automatic logic edge_hit(input triple_timer_pkg::edge_t e, input logic r,
                                    input logic f);
    edge_hit = (e[0] & r) | (e[1] & f);
  endfunction

  // Prescaled tick: bit k of the divider toggling doubles the period per step.
  function automatic logic presc_tick(input logic [2:0] p, input logic [15:0] d, input logic b);
    logic [15:0] mask;
    mask = (16'h0001 << p) - 16'h0001;
    presc_tick = b && ((d & mask) == mask);
  endfunction

  assign tl_rise = ovf[`TT_IDX_CORE] | unf[`TT_IDX_CORE] ? ~core_toggle_latch : 1'b0;
  assign tl_fall = ovf[`TT_IDX_CORE] | unf[`TT_IDX_CORE] ? core_toggle_latch : 1'b0;

  // Step and direction decision for each timer.
  for (genvar i = 0; i < 3; i++) begin : g_step
    triple_timer_pkg::timer_cfg_t c;
    logic quad_step, quad_down, pre, stopped, chain_hit;
    assign c = timer_cfg[i];
    assign pre = presc_tick(c.prescale, div_ff, base_tick);
    // A leads B counts up; either edge of either track is one step.
    assign quad_step = in_rise[i] | in_fall[i] | dir_rise[i] | dir_fall[i];
    assign quad_down = (in_rise[i] | in_fall[i]) ?
                       ((in_rise[i] | in_fall[i]) & (in_s2_ff[i] == dir_lvl_ff[i])) :
                       (dir_s2_ff[i] != in_lvl_ff[i]);
    assign stopped = aux_cfg[i].capture | aux_cfg[i].reload; // see (RULE14)
    assign chain_hit = edge_hit(aux_cfg[i].trig_edge, tl_rise, tl_fall); // see (RULE10) (RULE13)
    always_comb begin
      step[i] = 1'b0;
      down[i] = c.dir_down ^ (c.ext_dir_en & dir_lvl_ff[i]); // see (RULE8)
      if (c.run && !stopped && clk_en) begin
        if (aux_cfg[i].chain) begin
          step[i] = chain_hit;
        end else begin
          case (c.mode) // see (RULE2) (RULE6)
            triple_timer_pkg::MODE_TIMER: step[i] = pre; // see (RULE3)
            triple_timer_pkg::MODE_GATED: step[i] = pre && (in_lvl_ff[i] == c.gate_high); // see (RULE5)
            triple_timer_pkg::MODE_COUNTER:
              step[i] = edge_hit(c.count_edge, in_rise[i], in_fall[i]); // see (RULE4)
            default: begin
              step[i] = quad_step; // see (RULE9)
              down[i] = quad_down;
            end
          endcase
        end
      end
    end
    assign ovf[i] = step[i] && !down[i] && cnt_ff[i] == TMAX; // see (RULE18)
    assign unf[i] = step[i] && down[i] && cnt_ff[i] == 16'h0000;
  end

  // Reload source: low auxiliary wins when both fire in one cycle.
  always_comb begin
    core_reload = 1'b0;
    reload_val = cnt_ff[`TT_IDX_LOW];
    for (int k = 2; k >= 0; k -= 2) begin
      if (clk_en && aux_cfg[k].reload &&
          (edge_hit(aux_cfg[k].trig_edge, in_rise[k], in_fall[k]) ||
           (aux_cfg[k].reload_on_rise && tl_rise) ||
           (aux_cfg[k].reload_on_fall && tl_fall))) begin // see (RULE16) (RULE17)
        core_reload = 1'b1;
        reload_val = cnt_ff[k];
      end
    end
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      nxt_cnt[k] = down[k] ? cnt_ff[k] - 16'h0001 : cnt_ff[k] + 16'h0001;
    end
  end

  // Counter registers; wrap is the natural modulo of the 16-bit add.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < 3; k++) begin
        cnt_ff[k] <= `TT_TIMER_RST; // see (RULE1)
      end
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (k == `TT_IDX_CORE && core_reload) begin
          cnt_ff[k] <= reload_val;
        end else if (k != `TT_IDX_CORE && clk_en && aux_cfg[k].capture &&
                     edge_hit(aux_cfg[k].trig_edge, in_rise[k], in_fall[k])) begin
          cnt_ff[k] <= cnt_ff[`TT_IDX_CORE]; // see (RULE15)
        end else if (step[k]) begin
          cnt_ff[k] <= nxt_cnt[k]; // see (RULE18)
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_toggle_latch <= 1'b0;
    end else if (ovf[`TT_IDX_CORE] | unf[`TT_IDX_CORE]) begin
      core_toggle_latch <= ~core_toggle_latch; // see (RULE11)
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_output_pin <= 1'b0;
    end else if (clk_en) begin
      toggle_output_pin <= toggle_out_en & core_toggle_latch; // see (RULE12)
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_pulse <= 3'h0;
      underflow_pulse <= 3'h0;
    end else if (clk_en) begin
      overflow_pulse <= ovf;
      underflow_pulse <= unf;
    end
  end

  assign aux_timer_low = cnt_ff[`TT_IDX_LOW];
  assign core_timer = cnt_ff[`TT_IDX_CORE];
  assign aux_timer_high = cnt_ff[`TT_IDX_HIGH];

  // Checks.
  base_period_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE7)
    base_tick |=> !base_tick [*7])
    else $error("base tick closer than eight cycles");
  toggle_flip_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE11)
    (ovf[1] | unf[1]) |=> core_toggle_latch != $past(core_toggle_latch))
    else $error("toggle latch missed a wrap");
  toggle_steady_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE11)
    !(ovf[1] | unf[1]) |=> $stable(core_toggle_latch))
    else $error("toggle latch moved without a wrap");
  toggle_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE12)
    (clk_en && toggle_out_en) |=> toggle_output_pin == $past(core_toggle_latch))
    else $error("toggle pin does not follow latch");
  aux_stopped_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE14)
    (aux_cfg[0].capture | aux_cfg[0].reload) |-> !step[0])
    else $error("low auxiliary counted while stopped");
  core_capture_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE15)
    (clk_en && aux_cfg[2].capture && edge_hit(aux_cfg[2].trig_edge, in_rise[2], in_fall[2]))
    |=> aux_timer_high == $past(core_timer))
    else $error("capture value wrong");
  core_reload_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE16)
    core_reload |=> core_timer == $past(reload_val))
    else $error("core reload value wrong");
  up_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE18)
    (ovf[0] && !aux_cfg[0].capture) |=> aux_timer_low == 16'h0000 && overflow_pulse[0])
    else $error("overflow did not wrap to zero");
  down_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE18)
    (unf[2] && !aux_cfg[2].capture) |=> aux_timer_high == 16'hFFFF && underflow_pulse[2])
    else $error("underflow did not wrap to max");
  gate_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE5)
    (timer_cfg[0].mode == triple_timer_pkg::MODE_GATED && !aux_cfg[0].capture &&
     in_lvl_ff[0] != timer_cfg[0].gate_high && !aux_cfg[0].chain) |=> $stable(aux_timer_low))
    else $error("gated timer counted with gate closed");
  sync_delay_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE19)
    (clk_en && in_rise[1]) |-> $past(in_s1_ff[1], 2) == 1'b1)
    else $error("edge seen before synchroniser");

  // A disagreeing synchroniser pair must never move the accepted level.
  sync_level_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE19)
    (clk_en && in_s2_ff[0] != in_s3_ff[0])
    |=> in_lvl_ff[0] == $past(in_lvl_ff[0]))
    else $error("input level moved while stages disagree");
  timer_tick_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE3)
    (step[1] && timer_cfg[1].mode == triple_timer_pkg::MODE_TIMER)
    |-> base_tick)
    else $error("timer mode stepped off the base tick");
  counter_edge_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE4)
    (step[0] && timer_cfg[0].mode == triple_timer_pkg::MODE_COUNTER && !aux_cfg[0].chain)
    |-> (in_rise[0] | in_fall[0]))
    else $error("counter stepped without a pin edge");
  run_stop_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE2)
    !timer_cfg[1].run
    |-> !step[1])
    else $error("core stepped while not running");
  core_ovf_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE18)
    (ovf[1] && !core_reload)
    |=> core_timer == 16'h0000)
    else $error("core overflow did not wrap to zero");
  core_unf_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE18)
    (unf[1] && !core_reload)
    |=> core_timer == 16'hFFFF)
    else $error("core underflow did not wrap to max");
  quad_step_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE9)
    (clk_en && timer_cfg[0].run && timer_cfg[0].mode == triple_timer_pkg::MODE_INCREMENTAL &&
     !aux_cfg[0].chain && !aux_cfg[0].capture && !aux_cfg[0].reload &&
     (in_rise[0] | in_fall[0] | dir_rise[0] | dir_fall[0])) |-> step[0])
    else $error("sensor edge not counted");
  chain_count_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE13)
    (clk_en && timer_cfg[0].run && aux_cfg[0].chain && !aux_cfg[0].capture &&
     !aux_cfg[0].reload && aux_cfg[0].trig_edge == triple_timer_pkg::EDGE_BOTH &&
     (tl_rise | tl_fall)) |-> step[0])
    else $error("chained timer missed a latch edge");
  dir_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE8)
    (timer_cfg[1].ext_dir_en && timer_cfg[1].mode == triple_timer_pkg::MODE_TIMER)
    |-> down[1] == (timer_cfg[1].dir_down ^ dir_lvl_ff[1]))
    else $error("direction pin not applied");
  reload_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE16)
    (clk_en && aux_cfg[2].reload && edge_hit(aux_cfg[2].trig_edge, in_rise[2], in_fall[2]))
    |-> core_reload)
    else $error("pin edge did not reload core");
  latch_reload_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE17)
    (clk_en && aux_cfg[2].reload && aux_cfg[2].reload_on_rise && tl_rise)
    |-> core_reload)
    else $error("latch edge did not reload core");
  pulse_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE18)
    (clk_en && !ovf[1])
    |=> !overflow_pulse[1])
    else $error("overflow pulse without a wrap");
  high_stopped_a: assert property (@(posedge clk) disable iff (sys_rst) // see (RULE14)
    (aux_cfg[2].capture | aux_cfg[2].reload)
    |-> !step[2])
    else $error("high auxiliary counted while stopped");

  chain_c: cover property (@(posedge clk) disable iff (sys_rst)
    aux_cfg[0].chain && step[0]);
  core_ovf_c: cover property (@(posedge clk) disable iff (sys_rst) ovf[1]);
  core_unf_c: cover property (@(posedge clk) disable iff (sys_rst) unf[1]);
  pwm_reload_c: cover property (@(posedge clk) disable iff (sys_rst)
    core_reload && aux_cfg[0].reload && aux_cfg[2].reload);
  capture_c: cover property (@(posedge clk) disable iff (sys_rst)
    aux_cfg[0].capture && in_rise[0]);
endmodule

// [tb/sensor_model.sv]
// Model of the external event pins and the quadrature position sensor.
module sensor_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic [2:0] in_pin,
  output logic [2:0] dir_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial in_pin = 3'h0;
  initial dir_pin = 3'h0;
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic set_in(input int i, input logic v);
    in_pin[i] = v;
    hold(1);
  endtask
  task automatic set_dir(input int i, input logic v);
    dir_pin[i] = v;
    hold(1);
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      in_pin[i] = 1'b1;
      hold(4);
      in_pin[i] = 1'b0;
      hold(4);
    end
  endtask
  // Forward motion has A leading B, and each step moves one signal only.
  task automatic quad(input int i, input int n, input logic fwd);
    repeat (n) begin
      if ((in_pin[i] == dir_pin[i]) == fwd) in_pin[i] = ~in_pin[i];
      else dir_pin[i] = ~dir_pin[i];
      hold(4);
    end
  endtask
endmodule

// [tb/triple_timer_module_tb.sv]
// Self-checking bench for the three-timer module.
module triple_timer_module_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic ten = 1'b1;
  triple_timer_pkg::timer_cfg_t cfg [3];
  triple_timer_pkg::aux_cfg_t alc = '0;
  triple_timer_pkg::aux_cfg_t ahc = '0;
  logic [2:0] in_pin, dir_pin, of_p, uf_p;
  logic tpin, latch;
  logic last = 1'b0;
  logic [15:0] lo, core, hi, a, d0, d1;
  int n_mismatch = 0;
  int compares = 0;
  int n_of, n_uf, n_tog, p, k, n;
  always #25 clk = ~clk;
  triple_timer_module u_triple_timer_module (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .timer_cfg(cfg), .aux_low_cfg(alc), .aux_high_cfg(ahc), .toggle_out_en(ten),
    .timer_input_pin(in_pin), .direction_input_pin(dir_pin), .toggle_output_pin(tpin),
    .aux_timer_low(lo), .core_timer(core), .aux_timer_high(hi), .core_toggle_latch(latch),
    .overflow_pulse(of_p), .underflow_pulse(uf_p));
  sensor_model sensor (.clk(clk), .in_pin(in_pin), .dir_pin(dir_pin));
  always @(posedge clk) begin
    n_of += int'(of_p[1] | uf_p[1]);
    n_uf += int'(uf_p[2]);
    n_tog += int'(latch !== last);
    last <= latch;
  end
  function automatic logic [15:0] step(input logic [15:0] v, input int k, input logic dn);
    return dn ? v - 16'(k) : v + 16'(k);
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic clr();
    n_of = 0;
    n_uf = 0;
    n_tog = 0;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 3; i++) cfg[i] = '0;
    void'($urandom(15));
    repeat (12) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    chk16(core, 16'h0000);
    chk1(latch, 1'b0);
    for (int t = 0; t < 4; t++) begin
      p = $urandom % 3;
      k = 2 + $urandom % 3;
      for (int i = 0; i < 3; i++) begin
        cfg[i].run = 1'b1;
        cfg[i].prescale = 3'(p);
        cfg[i].dir_down = t[0];
      end
      cyc(2);
      a = core;
      d0 = lo;
      d1 = hi;
      cyc((8 << p) * k);
      chk16(core, step(a, k, t[0]));
      chk16(lo, step(d0, k, t[0]));
      chk16(hi, step(d1, k, t[0]));
    end
    cfg[1].dir_down = 1'b0;
    cfg[1].prescale = 3'h0;
    cfg[1].ext_dir_en = 1'b1;
    cyc(5);
    a = core;
    cyc(16);
    d0 = core - a;
    sensor.set_dir(1, 1'b1);
    cyc(5);
    a = core;
    cyc(16);
    d1 = core - a;
    chk16(d0 + d1, 16'h0000);
    chk1((d0 == 16'h0002) || (d0 == 16'hFFFE), 1'b1);
    sensor.set_dir(1, 1'b0);
    clk_en = 1'b0;
    a = core;
    cyc(40);
    chk16(core, a);
    clk_en = 1'b1;
    cfg[1].run = 1'b0;
    cfg[0] = '0;
    cfg[0].mode = triple_timer_pkg::MODE_COUNTER;
    cfg[0].run = 1'b1;
    for (int e = 0; e < 4; e++) begin
      cfg[0].count_edge = triple_timer_pkg::edge_t'(e);
      n = 1 + $urandom % 6;
      cyc(2);
      a = lo;
      sensor.pulse(0, n);
      cyc(6);
      chk16(lo, a + 16'(n * (e % 2 + e / 2)));
    end
    cfg[0].mode = triple_timer_pkg::MODE_GATED;
    cfg[0].gate_high = 1'b1;
    for (int g = 1; g >= 0; g--) begin
      sensor.set_in(0, g[0]);
      cyc(5);
      a = lo;
      cyc(32);
      chk16(lo, a + 16'(4 * g));
    end
    cfg[0].mode = triple_timer_pkg::MODE_INCREMENTAL;
    n = 2 + $urandom % 6;
    a = lo;
    sensor.quad(0, n, 1'b1);
    cyc(6);
    d0 = lo - a;
    a = lo;
    sensor.quad(0, n, 1'b0);
    cyc(6);
    d1 = lo - a;
    chk16(d0 + d1, 16'h0000);
    chk1((d0 == 16'(n)) || (d0 == -16'(n)), 1'b1);
    for (int i = 0; i < 3; i++) cfg[i] = '0;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    chk16(hi, 16'h0000);
    cfg[2].mode = triple_timer_pkg::MODE_COUNTER;
    cfg[2].run = 1'b1;
    cfg[2].dir_down = 1'b1;
    cfg[2].count_edge = triple_timer_pkg::EDGE_RISE;
    clr();
    sensor.pulse(2, 1);
    cyc(4);
    chk16(hi, 16'hFFFF);
    chk16(16'(n_uf), 16'h0001);
    ahc.reload = 1'b1;
    ahc.trig_edge = triple_timer_pkg::EDGE_RISE;
    sensor.pulse(2, 1);
    cyc(4);
    chk16(core, 16'hFFFF);
    chk16(hi, 16'hFFFF);
    cfg[1].run = 1'b1;
    n = 0;
    while (of_p[1] !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk1(of_p[1], 1'b1);
    chk16(core, 16'h0000);
    chk1(latch, 1'b1);
    cyc(1);
    chk1(tpin, 1'b1);
    ten = 1'b0;
    cyc(2);
    chk1(tpin, 1'b0);
    ten = 1'b1;
    cfg[1].run = 1'b0;
    ahc.reload_on_rise = 1'b1;
    ahc.reload_on_fall = 1'b1;
    alc.chain = 1'b1;
    alc.trig_edge = triple_timer_pkg::EDGE_BOTH;
    cfg[0].run = 1'b1;
    sensor.pulse(2, 1);
    cyc(4);
    clr();
    a = lo;
    cfg[1].run = 1'b1;
    cyc(200);
    cfg[1].run = 1'b0;
    cyc(6);
    chk16(lo - a, 16'(n_tog));
    chk16(16'(n_of), 16'(n_tog));
    chk1(n_tog > 15, 1'b1);
    alc = '0;
    alc.capture = 1'b1;
    alc.trig_edge = triple_timer_pkg::EDGE_RISE;
    sensor.pulse(0, 1);
    cyc(4);
    chk16(lo, core);
    a = lo;
    cyc(32);
    chk16(lo, a);
    end_of_test();
  end
endmodule
